// >>> wsw_consts.vh
`ifndef WSW_CONSTS_VH
`define WSW_CONSTS_VH
// register indices; the bus address of each is four times its index
`define WSW_IDX_OPTION 16'h0081
`define WSW_IDX_CONFIG 16'h2007
`define WSW_ADDR_OPTION 16'h0204
`define WSW_ADDR_CONFIG 16'h801c
`define WSW_ADDR_STATUS 16'h0300
`define WSW_ADDR_CTRL 16'h0304
`define WSW_ADDR_WAKEEN 16'h0308
// option register fields
`define WSW_OPT_PSA 3
`define WSW_OPT_PS_HI 2
`define WSW_OPT_PS_LO 0
`define WSW_OPT_RESET 8'hff
// configuration word fields
`define WSW_CFG_WATCHDOG_FUSE_ENABLE 2
`define WSW_CFG_FOSC_HI 1
`define WSW_CFG_FOSC_LO 0
`define WSW_CFG_RESET 8'hff
`define WSW_FOSC_RC 2'h3
// status bits
`define WSW_ST_TO 4
`define WSW_ST_PD 3
// control register bits
`define WSW_CTL_GIE 7
// oscillator start-up: 1024 oscillator periods
`define WSW_OST_TOSC 1024
`define WSW_OST_CYCLES (`WSW_OST_TOSC)
`define WSW_OST_W 11
// watchdog base period in rc ticks (default)
`define WSW_WDT_TICKS 18
`define WSW_WDT_W 18
`define WSW_RC_DIV 16
`define WSW_RC_W 4
`define WSW_VECTOR 16'h0004
`endif

// >>> wsw_watchdog_sleep.v
`timescale 1ns/1ps
`include "wsw_consts.vh"
//
// Notes on behaviour
// - watchdog runs from own free-running rc
// - expiry while running forces watchdog reset
// - expiry while asleep wakes and resumes
// - every expiry clears timeout flag bit 4
// - cleared fuse bit disables watchdog permanently
// - option register assigns prescaler, selects ratio
// - clear or sleep resets counter and scaler
// - clear zeroes prescaler only while assigned to watchdog, keeps its assignment
// - sleep clears pd, sets to, stops oscillator
// - pins keep their drive state in sleep
// - wake on master clear, watchdog, interrupt
// - master clear resets, others resume execution
// - pd set at power-up, cleared by sleep
// - only listed peripherals can wake device
// - clock-bound peripherals cannot interrupt in sleep
// - sleep prefetches the following instruction
// - wake needs individual enable, ignores gie
// - gie clear continues, set vectors after prefetch
// - pending interrupt makes sleep a no-op
// - interrupt during sleep completes sleep, wakes
// - crystal modes wait start-up delay, rc none
// - gie is control bit 7, reset clears
module wsw_watchdog_sleep #(
	parameter WDT_TICKS = `WSW_WDT_TICKS
) (
	input wire clock_in,
	input wire arst_n_in,
	// apb slave
	input wire psel_in,
	input wire penable_in,
	input wire pwrite_in,
	input wire [15:0] paddr_in,
	input wire [31:0] pwdata_in,
	output wire pready_out,
	output reg [31:0] prdata_out,
	output wire pslverr_out,
	// core side
	input wire watchdog_clear_instr_in,
	input wire sleep_instr_in,
	input wire [7:0] config_word_in,
	input wire master_clear_n_in,
	input wire ext_int_flag_in,
	input wire portb_change_flag_in,
	input wire [8:0] periph_flag_in,
	input wire [15:0] pc_in,
	input wire [7:0] pins_drive_in,
	input wire [7:0] pins_oe_n_in,
	output reg device_reset_out,
	output reg watchdog_reset_out,
	output reg asleep_out,
	output reg osc_driver_on_out,
	output reg core_run_out,
	output reg vector_out,
	output reg [15:0] vector_addr_out,
	output reg [15:0] prefetch_addr_out,
	output reg [7:0] pins_drive_out,
	output reg [7:0] pins_oe_n_out,
	output reg timeout_flag_n_out,
	output reg powerdown_flag_n_out
);

	// states, one-hot
	localparam ST_RUN = 4'h1;
	localparam ST_SLEEP = 4'h2;
	localparam ST_OST = 4'h4;
	localparam ST_RST = 4'h8;

	reg [3:0] state_reg, state_next; // sleep controller state
	reg [7:0] option_reg; // prescaler option register
	reg [7:0] config_reg; // fuse word, caught after reset release
	reg cfg_loaded_reg; // fuse capture done
	reg gie_reg; // global interrupt enable
	reg [10:0] wake_en_reg; // individual wake enables
	reg [`WSW_RC_W-1:0] rc_div_reg; // internal rc oscillator model
	reg [`WSW_WDT_W-1:0] wdt_cnt_reg; // watchdog base counter
	reg [7:0] psc_cnt_reg; // shared prescaler count
	reg [`WSW_OST_W-1:0] ost_cnt_reg; // start-up delay counter
	reg master_clear_n_s1_reg, master_clear_n_s2_reg; // master clear synchroniser
	reg [10:0] flg_s1_reg, flg_s2_reg; // interrupt flag synchroniser
	reg wake_gie_reg; // gie value latched at wake

	wire rc_tick; // one tick of the rc oscillator
	wire wdt_en; // fuse enable
	wire prescaler_assign; // prescaler on watchdog
	wire [2:0] ps_sel; // prescale ratio select
	wire [7:0] ps_mask; // prescaler terminal mask
	wire base_done; // base period reached
	wire scaler_done; // scaler terminal reached
	wire expiry; // watchdog expires
	wire [10:0] pend_vec; // enabled pending interrupts
	wire pend; // any enabled interrupt pending
	wire wclr; // watchdog clear event
	wire sleep_take; // sleep actually executes
	wire rc_osc; // rc oscillator mode

	// sleep control in brief: run -> sleep on a taken sleep strobe,
	// sleep -> run or start-up on wake, run -> reset pulse on expiry.
	// the start-up state only exists for crystal or resonator fuses;
	// in rc mode the core resumes on the cycle after the wake event.
	// the watchdog keeps counting in every state, so an expiry while
	// asleep is a wake and an expiry while running is a reset.
	// master clear overrides everything and holds the core in reset
	// for as long as the synchronised pin stays low.

	// the rc runs regardless of the core clock gate; it is a divided tick
	// here because the block has one clock
	// limitation: the real rc drifts with supply and temperature, this
	// model ticks at an exact fraction of the system clock, so timeout
	// periods are exact here and only nominal on silicon
	// the divider is never gated by sleep or by the core state
	always @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rc_div_reg <= {`WSW_RC_W{1'b0}};
		end else begin
			rc_div_reg <= rc_div_reg + 1'b1;
		end
	end
	assign rc_tick = (rc_div_reg == {`WSW_RC_W{1'b1}});

	// pin synchronisers; the first stage feeds only the second
	// master clear idles high, so both stages reset high to avoid a
	// false reset pulse right after release
	// interrupt flags cost two cycles of wake latency through here
	always @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			master_clear_n_s1_reg <= 1'b1;
			master_clear_n_s2_reg <= 1'b1;
			flg_s1_reg <= 11'h000;
			flg_s2_reg <= 11'h000;
		end else begin
			master_clear_n_s1_reg <= master_clear_n_in;
			master_clear_n_s2_reg <= master_clear_n_s1_reg;
			flg_s1_reg <= {periph_flag_in, portb_change_flag_in,
				ext_int_flag_in};
			flg_s2_reg <= flg_s1_reg;
		end
	end

	assign wdt_en = config_reg[`WSW_CFG_WATCHDOG_FUSE_ENABLE];
	assign prescaler_assign = option_reg[`WSW_OPT_PSA];
	assign ps_sel = option_reg[`WSW_OPT_PS_HI:`WSW_OPT_PS_LO];
	assign ps_mask = (8'h01 << ps_sel) - 8'h01;
	assign rc_osc = (config_reg[`WSW_CFG_FOSC_HI:`WSW_CFG_FOSC_LO]
		== `WSW_FOSC_RC);
	// only listed wake sources reach here; clocked peripherals are not
	// wired in, so nothing clock-bound can wake the core
	assign pend_vec = flg_s2_reg & wake_en_reg;
	assign pend = |pend_vec;
	assign base_done = (wdt_cnt_reg == WDT_TICKS[`WSW_WDT_W-1:0] - 1'b1);
	assign scaler_done = !prescaler_assign || ((psc_cnt_reg & ps_mask) == ps_mask);
	assign expiry = wdt_en && rc_tick && base_done && scaler_done;
	// sleep with a pending enabled interrupt is a no-op
	// an expiry in the same cycle wins: the reset must not leave asleep set
	assign sleep_take = sleep_instr_in && !pend && !expiry &&
		(state_reg == ST_RUN);
	assign wclr = (watchdog_clear_instr_in || sleep_take) &&
		(state_reg == ST_RUN);

	// watchdog counter and shared prescaler
	// the base counter divides rc ticks down to one base period; the
	// prescaler then counts base periods when it is assigned here
	// a clear and an expiry both restart the period from zero
	// the prescaler is only cleared while assigned to the watchdog, so
	// a timer user elsewhere keeps its count across a clear
	// a cleared fuse holds both counters at zero for good
	always @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			wdt_cnt_reg <= {`WSW_WDT_W{1'b0}};
			psc_cnt_reg <= 8'h00;
		end else if (!wdt_en || wclr || expiry) begin
			wdt_cnt_reg <= {`WSW_WDT_W{1'b0}};
			if (prescaler_assign) begin
				psc_cnt_reg <= 8'h00;
			end
		end else if (rc_tick) begin
			if (base_done) begin
				wdt_cnt_reg <= {`WSW_WDT_W{1'b0}};
				if (prescaler_assign) begin
					psc_cnt_reg <= psc_cnt_reg + 8'h01;
				end
			end else begin
				wdt_cnt_reg <= wdt_cnt_reg + 1'b1;
			end
		end
	end

	// next-state logic
	// expiry has priority over a sleep strobe in the run state
	// in sleep, either an enabled flag or an expiry ends the nap
	// the start-up state counts a fixed number of cycles and cannot
	// be cut short except by master clear
	// the reset state lasts a single cycle and then runs again
	// any illegal code falls back to run
	always @* begin
		state_next = state_reg;
		case (state_reg)
			ST_RUN: begin
				if (expiry) begin
					state_next = ST_RST;
				end else if (sleep_take) begin
					state_next = ST_SLEEP;
				end
			end
			ST_SLEEP: begin
				// a flag that turns pending after entry, or an expiry, wakes at once
				if (expiry || pend) begin
					state_next = rc_osc ? ST_RUN : ST_OST;
				end
			end
			ST_OST: begin
				if (ost_cnt_reg == `WSW_OST_CYCLES - 1) begin
					state_next = ST_RUN;
				end
			end
			ST_RST: begin
				state_next = ST_RUN;
			end
			default: begin
				state_next = ST_RUN;
			end
		endcase
	end

	// state, flags, outputs
	// all core-facing outputs are registered so the core never sees a
	// glitch from the decode of state and strobes
	// the timeout flag: an expiry in the same cycle as a clear wins,
	// since losing the expiry would hide a watchdog event from software
	// the power-down flag is only set by the power-on reset; master
	// clear keeps both flags so software can tell the cause
	// pin state is copied only while running; sleep and start-up freeze
	// the last drive and enable values
	always @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state_reg <= ST_RUN;
			ost_cnt_reg <= {`WSW_OST_W{1'b0}};
			timeout_flag_n_out <= 1'b1;
			powerdown_flag_n_out <= 1'b1;
			device_reset_out <= 1'b0;
			watchdog_reset_out <= 1'b0;
			asleep_out <= 1'b0;
			osc_driver_on_out <= 1'b1;
			core_run_out <= 1'b1;
			vector_out <= 1'b0;
			vector_addr_out <= 16'h0000;
			prefetch_addr_out <= 16'h0000;
			pins_drive_out <= 8'h00;
			pins_oe_n_out <= 8'hff;
			wake_gie_reg <= 1'b0;
		end else if (!master_clear_n_s2_reg) begin
			// master clear: full reset, flags untouched
			state_reg <= ST_RUN;
			ost_cnt_reg <= {`WSW_OST_W{1'b0}};
			device_reset_out <= 1'b1;
			watchdog_reset_out <= 1'b0;
			asleep_out <= 1'b0;
			osc_driver_on_out <= 1'b1;
			core_run_out <= 1'b0;
			vector_out <= 1'b0;
		end else begin
			state_reg <= state_next;
			device_reset_out <= 1'b0;
			watchdog_reset_out <= 1'b0;
			vector_out <= 1'b0;
			ost_cnt_reg <= (state_reg == ST_OST) ?
				ost_cnt_reg + 1'b1 : {`WSW_OST_W{1'b0}};
			if (expiry) begin
				timeout_flag_n_out <= 1'b0;
			end else if (wclr) begin
				timeout_flag_n_out <= 1'b1;
			end
			if (sleep_take) begin
				powerdown_flag_n_out <= 1'b0;
				prefetch_addr_out <= pc_in + 16'h0001;
				osc_driver_on_out <= 1'b0;
				asleep_out <= 1'b1;
				core_run_out <= 1'b0;
			end
			if (state_reg == ST_RUN) begin
				// pins follow the core only while awake
				pins_drive_out <= pins_drive_in;
				pins_oe_n_out <= pins_oe_n_in;
			end
			if (state_reg == ST_RUN && expiry) begin
				device_reset_out <= 1'b1;
				watchdog_reset_out <= 1'b1;
				core_run_out <= 1'b0;
			end
			if (state_reg == ST_RST) begin
				core_run_out <= 1'b1;
			end
			if (state_reg == ST_SLEEP && state_next != ST_SLEEP) begin
				osc_driver_on_out <= 1'b1;
				wake_gie_reg <= gie_reg && !expiry;
				asleep_out <= 1'b0;
			end
			if ((state_reg == ST_SLEEP || state_reg == ST_OST) &&
				state_next == ST_RUN) begin
				// resume at the prefetched instruction, then vector
				core_run_out <= 1'b1;
				vector_out <= (state_reg == ST_SLEEP) ?
					(gie_reg && !expiry) : wake_gie_reg;
				vector_addr_out <= `WSW_VECTOR;
			end
		end
	end

	// apb registers; zero-wait, always ready
	// every access completes in its first access cycle
	// the error response is combinational and only raised in the
	// access phase, never in setup
	// unmapped writes are dropped and unmapped reads return zero
	// the decode compares full addresses, so aliases are refused too
	assign pready_out = 1'b1;
	assign pslverr_out = psel_in && penable_in &&
		!(paddr_in == `WSW_ADDR_OPTION || paddr_in == `WSW_ADDR_CONFIG ||
		paddr_in == `WSW_ADDR_STATUS || paddr_in == `WSW_ADDR_CTRL ||
		paddr_in == `WSW_ADDR_WAKEEN);

	// register writes; fuse word is captured once after release
	// trade-off: the fuse is sampled a cycle late, so its reset value
	// must enable the watchdog harmlessly for that first cycle
	// global enable is cleared by master clear and by watchdog reset
	// the status flags are read-only through this bus
	always @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			option_reg <= `WSW_OPT_RESET;
			config_reg <= `WSW_CFG_RESET;
			cfg_loaded_reg <= 1'b0;
			gie_reg <= 1'b0;
			wake_en_reg <= 11'h000;
		end else begin
			if (!cfg_loaded_reg) begin
				// fuse is read-only afterwards: disable stays permanent
				config_reg <= config_word_in;
				cfg_loaded_reg <= 1'b1;
			end
			if (!master_clear_n_s2_reg || (state_reg == ST_RUN && expiry)) begin
				gie_reg <= 1'b0;
			end else if (psel_in && penable_in && pwrite_in) begin
				case (paddr_in)
					`WSW_ADDR_OPTION: begin
						option_reg <= pwdata_in[7:0];
					end
					`WSW_ADDR_CTRL: begin
						gie_reg <= pwdata_in[`WSW_CTL_GIE];
					end
					`WSW_ADDR_WAKEEN: begin
						wake_en_reg <= pwdata_in[10:0];
					end
					default: begin
					end
				endcase
			end
		end
	end

	// read mux, registered data output
	// data is loaded in the setup cycle and stands through access
	// so the master may sample it at the completing edge
	// it holds its value until the next read setup
	// unused upper bits always read as zero
	always @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			prdata_out <= 32'h00000000;
		end else if (psel_in && !penable_in && !pwrite_in) begin
			case (paddr_in)
				`WSW_ADDR_OPTION: prdata_out <= {24'h000000, option_reg};
				`WSW_ADDR_CONFIG: prdata_out <= {24'h000000, config_reg};
				`WSW_ADDR_STATUS: prdata_out <= {27'h0000000,
					timeout_flag_n_out, powerdown_flag_n_out, 3'h0};
				`WSW_ADDR_CTRL: prdata_out <= {24'h000000, gie_reg, 7'h00};
				`WSW_ADDR_WAKEEN: prdata_out <= {21'h000000, wake_en_reg};
				default: prdata_out <= 32'h00000000;
			endcase
		end
	end

endmodule // wsw_watchdog_sleep

// >>> wsw_props.sv
`timescale 1ns/1ps
// watches the sleep, wake and watchdog outputs of the top module
module wsw_props (
	input wire clock_in,
	input wire arst_n_in,
	input wire psel_in,
	input wire penable_in,
	input wire [15:0] paddr_in,
	input wire pslverr_out,
	input wire master_clear_n_in,
	input wire [7:0] config_word_in,
	input wire [15:0] pc_in,
	input wire device_reset_out,
	input wire watchdog_reset_out,
	input wire asleep_out,
	input wire osc_driver_on_out,
	input wire core_run_out,
	input wire vector_out,
	input wire [15:0] vector_addr_out,
	input wire [15:0] prefetch_addr_out,
	input wire [7:0] pins_drive_out,
	input wire [7:0] pins_oe_n_out,
	input wire timeout_flag_n_out,
	input wire powerdown_flag_n_out
);
	default clocking wsw_cb @(posedge clock_in); endclocking
	default disable iff (!arst_n_in);
	wdog_full_reset_a: assert property (watchdog_reset_out |->
		device_reset_out)
		else $error("watchdog reset without device reset");
	wdog_flag_a: assert property ($rose(watchdog_reset_out) |->
		##[0:1] !timeout_flag_n_out)
		else $error("timeout flag not cleared on expiry");
	sleep_no_reset_a: assert property (asleep_out |->
		!watchdog_reset_out)
		else $error("reset raised while asleep");
	sleep_flags_a: assert property ($rose(asleep_out) |->
		!powerdown_flag_n_out && timeout_flag_n_out)
		else $error("flags wrong on sleep entry");
	sleep_osc_a: assert property (asleep_out |->
		!osc_driver_on_out && !core_run_out)
		else $error("oscillator or core running in sleep");
	pins_hold_a: assert property (asleep_out && $past(asleep_out) |->
		$stable(pins_drive_out) && $stable(pins_oe_n_out))
		else $error("pins moved during sleep");
	prefetch_addr_a: assert property ($rose(asleep_out) |->
		prefetch_addr_out == pc_in + 16'h0001)
		else $error("prefetch address wrong");
	vector_addr_a: assert property (vector_out |->
		vector_addr_out == 16'h0004)
		else $error("vector address wrong");
	master_clear_n_reset_a: assert property ((!master_clear_n_in) [*4] |->
		device_reset_out)
		else $error("master clear did not reset");
	unmapped_err_a: assert property (psel_in && penable_in &&
		paddr_in == 16'h0400 |-> pslverr_out)
		else $error("unmapped access not refused");
	fuse_off_a: assert property (!config_word_in[2] |->
		!watchdog_reset_out)
		else $error("watchdog reset with fuse off");
	vector_run_a: assert property (vector_out |-> core_run_out)
		else $error("vector while core held");
endmodule // wsw_props
bind wsw_watchdog_sleep wsw_props wsw_props_i (.clock_in, .arst_n_in,
	.psel_in, .penable_in, .paddr_in, .pslverr_out, .master_clear_n_in,
	.config_word_in, .pc_in,
	.device_reset_out, .watchdog_reset_out, .asleep_out, .osc_driver_on_out,
	.core_run_out, .vector_out, .vector_addr_out, .prefetch_addr_out,
	.pins_drive_out, .pins_oe_n_out, .timeout_flag_n_out, .powerdown_flag_n_out);

// >>> wsw_core_model.sv
`timescale 1ns/1ps
// processor core: issues one-cycle instruction strobes
module wsw_core_model (
	input wire clock_in,
	output reg clear_out,
	output reg sleep_out,
	output reg [15:0] pc_out
);
	// pc held still so the prefetch has a fixed expectation
	initial begin
		clear_out = 1'b0;
		sleep_out = 1'b0;
		pc_out = 16'h0123;
	end
	// software clears the watchdog when it must stay clear
	task run_clear;
		begin
			@(posedge clock_in);
			clear_out <= 1'b1;
			@(posedge clock_in);
			clear_out <= 1'b0;
		end
	endtask
	// sleep strobe, one cycle wide
	task run_sleep;
		begin
			@(posedge clock_in);
			sleep_out <= 1'b1;
			@(posedge clock_in);
			sleep_out <= 1'b0;
		end
	endtask
endmodule // wsw_core_model

// >>> wsw_watchdog_sleep_bench.sv
`timescale 1ns/1ps
module wsw_watchdog_sleep_bench;
	typedef struct {logic [15:0] a; logic [31:0] m;
		logic [31:0] e; logic er;} wsw_row_t;
	logic [7:0] cfg;
	int n;
	logic clock_in, arst_n_in, psel, penable, pwrite, master_clear_n_n, ext;
	logic [15:0] paddr;
	logic [31:0] pwdata, rd;
	logic [7:0] pins_d;
	logic er, rst_seen, vec_seen;
	wire clr, slp, pready, pslverr, dev_rst, wd_rst, asleep, run, vec;
	wire to_n, pd_n;
	wire [15:0] pc, vaddr, pf;
	wire [31:0] prdata;
	wire [7:0] pins_out;
	int fails = 0;
	int samples_checked = 0;
	int g;
	// reads: option, fuse word, control (gie only), status, unmapped
	wsw_row_t rows [5] = '{'{16'h0204, 32'hff, 32'hff, 1'b0},
		'{16'h801c, 32'hff, 32'hff, 1'b0}, '{16'h0304, 32'h80, 32'h0, 1'b0},
		'{16'h0300, 32'h18, 32'h18, 1'b0},
		'{16'h0400, 32'hffffffff, 32'h0, 1'b1}};
	wsw_watchdog_sleep #(.WDT_TICKS(4))
		wsw_watchdog_sleep_i (.clock_in(clock_in),
		.arst_n_in(arst_n_in), .psel_in(psel), .penable_in(penable),
		.pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
		.pready_out(pready), .prdata_out(prdata), .pslverr_out(pslverr),
		.watchdog_clear_instr_in(clr), .sleep_instr_in(slp),
		.config_word_in(cfg), .master_clear_n_in(master_clear_n_n),
		.ext_int_flag_in(ext), .portb_change_flag_in(1'b0),
		.periph_flag_in(9'h000), .pc_in(pc), .pins_drive_in(pins_d),
		.pins_oe_n_in(8'h0f), .device_reset_out(dev_rst),
		.watchdog_reset_out(wd_rst), .asleep_out(asleep),
		.osc_driver_on_out(), .core_run_out(run), .vector_out(vec),
		.vector_addr_out(vaddr), .prefetch_addr_out(pf),
		.pins_drive_out(pins_out), .pins_oe_n_out(),
		.timeout_flag_n_out(to_n), .powerdown_flag_n_out(pd_n));
	wsw_core_model wsw_core_model_i (.clock_in(clock_in), .clear_out(clr),
		.sleep_out(slp), .pc_out(pc));
	always #4 clock_in = ~clock_in;
	// sticky monitors for one-cycle pulses
	always @(posedge clock_in) begin
		if (dev_rst === 1'b1) rst_seen <= 1'b1;
		if (vec === 1'b1) vec_seen <= 1'b1;
	end
	task end_sim;
		begin
			$display("checks %0d fails %0d", samples_checked, fails);
			if (fails == 0 && samples_checked > 0) $display("Test passed");
			else $display("Test failed");
			$finish;
		end
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] v);
		samples_checked++;
		if (v !== e) begin
			fails++;
			$display("[FAIL] %s exp %h got %h", nm, e, v);
		end
	endtask
	// apb transfer, held until pready is sampled high
	task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
		int n;
		begin
			@(posedge clock_in);
			psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
			@(posedge clock_in);
			penable <= 1;
			for (n = 0; n < 50; n++) begin
				@(posedge clock_in);
				if (pready === 1'b1) break;
			end
			if (n == 50) begin fails++; end_sim; end
			rd = prdata;
			er = pslverr;
			psel <= 0;
			penable <= 0;
		end
	endtask
	// bounded wait: 0 asleep, 1 running awake, 2 watchdog reset
	task waitfor(input int k);
		int n;
		begin
			for (n = 0; n < 9000; n++) begin
				@(posedge clock_in);
				if (k == 0 && asleep === 1'b1) return;
				if (k == 1 && run === 1'b1 && asleep === 1'b0) return;
				if (k == 2 && wd_rst === 1'b1) return;
			end
			fails++;
			end_sim;
		end
	endtask
	initial begin
		clock_in = 0; arst_n_in = 0; psel = 0; penable = 0; pwrite = 0;
		paddr = 0; pwdata = 0; master_clear_n_n = 1; ext = 0; pins_d = 8'ha5;
		rst_seen = 0; vec_seen = 0;
		cfg = 8'hff;
		repeat (10) @(posedge clock_in);
		arst_n_in <= 1;
		repeat (2) @(posedge clock_in);
		chk("pd_reset", 1, pd_n);
		chk("to_reset", 1, to_n);
		foreach (rows[i]) begin
			apb(0, rows[i].a, 0);
			chk("rdata", rows[i].e, rd & rows[i].m);
			chk("slverr", rows[i].er, er);
		end
		apb(1, 16'h0308, 32'h1);
		// enabled flag already pending: sleep must do nothing
		ext <= 1;
		repeat (4) @(posedge clock_in);
		wsw_core_model_i.run_sleep;
		repeat (3) @(posedge clock_in);
		chk("noop_pd", 1, pd_n);
		chk("noop_sleep", 0, asleep);
		ext <= 0;
		repeat (4) @(posedge clock_in);
		// interrupt wake with gie clear, then set
		for (g = 0; g < 2; g++) begin
			apb(1, 16'h0304, g ? 32'h80 : 32'h0);
			vec_seen = 0;
			wsw_core_model_i.run_sleep;
			waitfor(0);
			chk("pd_sleep", 0, pd_n);
			chk("to_sleep", 1, to_n);
			chk("prefetch", 16'h0124, pf);
			pins_d <= 8'h5a;
			repeat (4) @(posedge clock_in);
			chk("pins", 8'ha5, pins_out);
			ext <= 1;
			waitfor(1);
			repeat (3) @(posedge clock_in);
			chk("vector", g, vec_seen);
			ext <= 0;
			pins_d <= 8'ha5;
			repeat (4) @(posedge clock_in);
		end
		chk("vaddr", 16'h0004, vaddr);
		// short watchdog period, then expiry while asleep
		apb(1, 16'h0304, 0);
		apb(1, 16'h0204, 32'h08);
		rst_seen = 0;
		wsw_core_model_i.run_sleep;
		waitfor(0);
		waitfor(1);
		chk("wake_rst", 0, rst_seen);
		chk("to_wake", 0, to_n);
		repeat (25) begin
			wsw_core_model_i.run_clear;
			repeat (20) @(posedge clock_in);
		end
		chk("clr_rst", 0, rst_seen);
		apb(0, 16'h0204, 0);
		chk("opt_kept", 32'h08, rd & 32'hff);
		waitfor(2);
		@(posedge clock_in);
		chk("to_run", 0, to_n);
		master_clear_n_n <= 0;
		repeat (5) @(posedge clock_in);
		chk("master_clear_n", 1, dev_rst);
		master_clear_n_n <= 1;
		repeat (5) @(posedge clock_in);
		// second reset: fuse off, crystal mode, so start-up delay applies
		arst_n_in <= 0;
		cfg <= 8'hf8;
		repeat (3) @(posedge clock_in);
		arst_n_in <= 1;
		repeat (2) @(posedge clock_in);
		chk("pd_reset2", 1, pd_n);
		chk("run_reset2", 1, run);
		apb(1, 16'h0204, 32'h08);
		apb(1, 16'h0308, 32'h1);
		apb(1, 16'h0304, 32'h80);
		rst_seen = 0;
		vec_seen = 0;
		repeat (200) @(posedge clock_in);
		chk("fuse_off", 0, rst_seen);
		chk("fuse_to", 1, to_n);
		wsw_core_model_i.run_sleep;
		waitfor(0);
		ext <= 1;
		for (n = 0; n < 2000; n++) begin
			if (run === 1'b1 && asleep === 1'b0) break;
			@(posedge clock_in);
		end
		chk("ost_wait", 1, n > 1024 && n < 1034);
		if (n == 2000) end_sim;
		repeat (3) @(posedge clock_in);
		chk("ost_vector", 1, vec_seen);
		ext <= 0;
		end_sim;
	end
endmodule // wsw_watchdog_sleep_bench
